// ---- core/rvl_ring_qual.v ----
// Ring validation qualifier with Avalon-MM register slave and interrupt.
// Assumes crossing events arrive as one-cycle pulses synchronous to the
// clock; one clock, asynchronous active-high reset.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "rvl_regs.vh"

module rvl_ring_qual #(
  parameter TICK_CYCLES = `RVL_TICK_US * `RVL_CLK_MHZ
) (
  input wire i_ref_clk,
  input wire i_sys_rst,
  input wire [7:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  input wire i_ring_event,
  output reg o_ring_valid,
  output reg o_irq
);
  localparam ST_IDLE = 2'd0;
  localparam ST_QUAL = 2'd1;
  localparam ST_DELAY = 2'd2;
  localparam ST_VALID = 2'd3;

  reg [7:0] ctrl_one;
  reg [7:0] ctrl_two;
  reg [7:0] ctrl_three;
  reg [2:0] irq_status;
  reg [2:0] irq_mask;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [5:0] assert_cnt;
  reg [9:0] since_evt;
  reg [9:0] phase_cnt;
  reg seen_evt;
  reg [2:0] next_status;
  reg ev_valid;
  reg ev_end;
  reg ev_invalid;
  reg freq_bad;
  wire tick;
  wire [2:0] dly_sel;
  wire [3:0] to_sel;
  wire [2:0] conf_sel;
  wire [5:0] max_lim;
  wire [5:0] assert_time;
  wire enable;
  wire [9:0] dly_ticks;
  wire [9:0] to_ticks;
  wire [9:0] conf_ticks;
  wire timed_out;
  wire bus_req;
  wire [7:0] idx;
  wire wr_done;
  wire rd_start;

  // Confirmation time in 2 ms steps for a code; halving is the tick
  function [9:0] conf_to_ticks;
    input [2:0] code;
    reg [10:0] ms;
    begin
      case (code)
        3'd0: ms = `RVL_CONF_T0_MS;
        3'd1: ms = `RVL_CONF_T1_MS;
        3'd2: ms = `RVL_CONF_T2_MS;
        3'd3: ms = `RVL_CONF_T3_MS;
        3'd4: ms = `RVL_CONF_T4_MS;
        3'd5: ms = `RVL_CONF_T5_MS;
        3'd6: ms = `RVL_CONF_T6_MS;
        default: ms = `RVL_CONF_T7_MS;
      endcase
      conf_to_ticks = ms[10:1];
    end
  endfunction

  // Code times a step in ms, expressed in 2 ms steps
  function [9:0] step_ticks;
    input [3:0] code;
    input [9:0] step_ms;
    reg [13:0] prod;
    begin
      prod = code * step_ms;
      step_ticks = prod[10:1];
    end
  endfunction

  rvl_tick_div #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .o_tick(tick)
  );

  assign dly_sel = {ctrl_two[`RVL_DLY_HI_BIT],
                    ctrl_one[`RVL_DLY_LO_MSB:`RVL_DLY_LO_LSB]};
  assign to_sel = ctrl_two[`RVL_TO_MSB:`RVL_TO_LSB];
  assign conf_sel = ctrl_two[`RVL_CONF_MSB:`RVL_CONF_LSB];
  assign max_lim = ctrl_one[`RVL_MAX_MSB:`RVL_MAX_LSB];
  assign assert_time = ctrl_three[`RVL_ASSERT_MSB:`RVL_ASSERT_LSB];
  assign enable = ctrl_three[`RVL_ENA_BIT];
  assign dly_ticks = step_ticks({1'b0, dly_sel}, `RVL_DLY_STEP_MS);
  assign to_ticks = step_ticks(to_sel, `RVL_TO_STEP_MS);
  assign conf_ticks = conf_to_ticks(conf_sel);
  // Code zero would end a ring at once; software must avoid it
  assign timed_out = (since_evt >= to_ticks);
  assign bus_req = i_avs_read | i_avs_write;
  assign idx = {2'b00, i_avs_address[7:2]};
  // Writes land where the master sees waitrequest low
  assign wr_done = i_avs_write && !o_avs_waitrequest;
  assign rd_start = i_avs_read && o_avs_waitrequest;

  // Frequency check on a crossing: too slow or too fast
  always @*
  begin
    freq_bad = 1'b0;
    if (seen_evt)
    begin
      if (assert_cnt == 6'h00)
        freq_bad = 1'b1;
      else if (assert_cnt > max_lim)
        freq_bad = 1'b1;
    end
  end

  // Ring sequence
  always @*
  begin
    next_state = state;
    ev_valid = 1'b0;
    ev_end = 1'b0;
    ev_invalid = 1'b0;
    if (!enable)
    begin
      // Bypass: any crossing indicates ring until the timeout
      if (i_ring_event)
        next_state = ST_VALID;
      else if (state != ST_IDLE && timed_out)
        next_state = ST_IDLE;
      else if (state != ST_IDLE)
        next_state = ST_VALID;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (i_ring_event)
            next_state = ST_QUAL;
        end
        ST_QUAL:
        begin
          if (i_ring_event && freq_bad)
            next_state = ST_IDLE;
          else if (timed_out)
            next_state = ST_IDLE;
          else if (tick && phase_cnt + 10'd1 >= conf_ticks)
            next_state = ST_DELAY;
        end
        ST_DELAY:
        begin
          if (i_ring_event && freq_bad)
            next_state = ST_IDLE;
          else if (timed_out)
            next_state = ST_IDLE;
          else if (phase_cnt >= dly_ticks)
            next_state = ST_VALID;
        end
        ST_VALID:
        begin
          // Frequency keeps being watched while the ring is shown
          if (i_ring_event && freq_bad)
            next_state = ST_IDLE;
          else if (timed_out)
            next_state = ST_IDLE;
        end
        default:
          next_state = ST_IDLE;
      endcase
    end
    if (next_state == ST_VALID && state != ST_VALID)
      ev_valid = 1'b1;
    if (state == ST_VALID && next_state == ST_IDLE)
      ev_end = 1'b1;
    if (enable && state != ST_IDLE && i_ring_event && freq_bad)
      ev_invalid = 1'b1;
  end

  always @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state <= ST_IDLE;
      phase_cnt <= 10'h000;
      seen_evt <= 1'b0;
      o_ring_valid <= 1'b0;
    end
    else
    begin
      state <= next_state;
      o_ring_valid <= (next_state == ST_VALID);
      // First crossing of a ring has nothing to compare against
      if (next_state == ST_IDLE)
        seen_evt <= 1'b0;
      else if (i_ring_event)
        seen_evt <= 1'b1;
      // Phase timer restarts on every change of state
      if (next_state != state)
        phase_cnt <= 10'h000;
      else if (tick && phase_cnt != 10'h3FF)
        phase_cnt <= phase_cnt + 10'h001;
    end
  end

  // Crossing timers run in every state, so a new ring starts with
  // a count that is already loaded
  always @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      assert_cnt <= 6'h00;
      since_evt <= 10'h000;
    end
    else
    begin
      // Down-counter: reload per crossing, one step per tick
      if (i_ring_event)
        assert_cnt <= assert_time;
      else if (tick && assert_cnt != 6'h00)
        assert_cnt <= assert_cnt - 6'h01;
      // Saturating time since latest crossing
      if (i_ring_event)
        since_evt <= 10'h000;
      else if (tick && since_evt != 10'h3FF)
        since_evt <= since_evt + 10'h001;
    end
  end

  // Sticky status; a new event wins over a same-cycle clear
  always @*
  begin
    next_status = irq_status;
    if (wr_done && idx == `RVL_IDX_IRQ_STATUS)
      next_status = next_status & ~i_avs_writedata[2:0];
    if (ev_valid)
      next_status[`RVL_IRQ_VALID] = 1'b1;
    if (ev_end)
      next_status[`RVL_IRQ_END] = 1'b1;
    if (ev_invalid)
      next_status[`RVL_IRQ_INVALID] = 1'b1;
  end

  // Interrupt level is taken from next_status, so it changes on the same edge as the status
  always @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      irq_status <= 3'h0;
      o_irq <= 1'b0;
    end
    else
    begin
      irq_status <= next_status;
      o_irq <= |(next_status & irq_mask);
    end
  end

  // Avalon handshake: one wait cycle, then the access completes
  always @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      if (bus_req && o_avs_waitrequest)
        o_avs_waitrequest <= 1'b0;
      else
        o_avs_waitrequest <= 1'b1;
      // Loaded on the first edge so it stands when the master takes it
      if (rd_start)
      begin
        case (idx)
          `RVL_IDX_CTRL_ONE:
            o_avs_readdata <= {24'h000000, ctrl_one};
          `RVL_IDX_CTRL_TWO:
            o_avs_readdata <= {24'h000000, ctrl_two};
          `RVL_IDX_CTRL_THREE:
            o_avs_readdata <= {24'h000000, ctrl_three};
          `RVL_IDX_IRQ_STATUS:
            o_avs_readdata <= {29'h00000000, irq_status};
          `RVL_IDX_IRQ_MASK:
            o_avs_readdata <= {29'h00000000, irq_mask};
          `RVL_IDX_RING_STATE:
            o_avs_readdata <= {24'h000000, o_ring_valid, 5'h00, state};
          default:
            o_avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control writes take effect only on the completing edge
  always @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ctrl_one <= `RVL_RST_CTRL_ONE;
      ctrl_two <= `RVL_RST_CTRL_TWO;
      ctrl_three <= `RVL_RST_CTRL_THREE;
      irq_mask <= `RVL_RST_IRQ_MASK;
    end
    else if (wr_done)
    begin
      case (idx)
        `RVL_IDX_CTRL_ONE:
          ctrl_one <= i_avs_writedata[7:0];
        `RVL_IDX_CTRL_TWO:
          ctrl_two <= i_avs_writedata[7:0];
        `RVL_IDX_CTRL_THREE:
          // Reserved bit kept at zero whatever is written
          ctrl_three <= i_avs_writedata[7:0] &
                        ~(8'h01 << `RVL_RSVD_BIT);
        `RVL_IDX_IRQ_MASK:
          irq_mask <= i_avs_writedata[2:0];
        default:
          ctrl_one <= ctrl_one;
      endcase
    end
  end
endmodule // rvl_ring_qual

// ---- core/rvl_regs.vh ----
// Register map, field layout, reset values and timing for the ring
// validation qualifier. Definitions only; included by the qualifier core, not the divider.
`ifndef RVL_REGS_VH
`define RVL_REGS_VH

// Register indices; byte address is four times the index
`define RVL_IDX_CTRL_ONE 8'h16
`define RVL_IDX_CTRL_TWO 8'h17
`define RVL_IDX_CTRL_THREE 8'h18
`define RVL_IDX_IRQ_STATUS 8'h20
`define RVL_IDX_IRQ_MASK 8'h21
`define RVL_IDX_RING_STATE 8'h22

// Reset values
`define RVL_RST_CTRL_ONE 8'h00
`define RVL_RST_CTRL_TWO 8'h2D
`define RVL_RST_CTRL_THREE 8'h19
`define RVL_RST_IRQ_MASK 3'h0

// ctrl_one fields: delay low bits and maximum-time field
`define RVL_DLY_LO_MSB 7
`define RVL_DLY_LO_LSB 6
`define RVL_MAX_MSB 5
`define RVL_MAX_LSB 0
// ctrl_two fields
`define RVL_DLY_HI_BIT 7
`define RVL_TO_MSB 6
`define RVL_TO_LSB 3
`define RVL_CONF_MSB 2
`define RVL_CONF_LSB 0
// ctrl_three fields
`define RVL_ENA_BIT 7
`define RVL_RSVD_BIT 6
`define RVL_ASSERT_MSB 5
`define RVL_ASSERT_LSB 0

// Interrupt status bits
`define RVL_IRQ_VALID 0
`define RVL_IRQ_END 1
`define RVL_IRQ_INVALID 2

// Timing
`define RVL_CLK_MHZ 250
`define RVL_TICK_US 2000
`define RVL_TICK_MS 2
// Sized to the function inputs so nothing is cut silently
`define RVL_DLY_STEP_MS 10'h100
`define RVL_TO_STEP_MS 10'h080
`define RVL_CONF_T0_MS 11'h064
`define RVL_CONF_T1_MS 11'h096
`define RVL_CONF_T2_MS 11'h0C8
`define RVL_CONF_T3_MS 11'h100
`define RVL_CONF_T4_MS 11'h180
`define RVL_CONF_T5_MS 11'h200
`define RVL_CONF_T6_MS 11'h280
`define RVL_CONF_T7_MS 11'h400

`endif

// ---- core/rvl_tick_div.v ----
// Fixed divider making the nominal 2 ms step enable for all timers.
// Assumes one free-running clock and an asynchronous active-high reset.
`timescale 1ns/1ns
module rvl_tick_div #(
  parameter TICK_CYCLES = 500000
) (
  input wire i_ref_clk,
  input wire i_sys_rst,
  output reg o_tick
);
  reg [31:0] count;

  always @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      count <= 32'h0000_0000;
      o_tick <= 1'b0;
    end
    else if (count >= TICK_CYCLES - 1)
    begin
      count <= 32'h0000_0000;
      o_tick <= 1'b1;
    end
    else
    begin
      count <= count + 32'h0000_0001;
      o_tick <= 1'b0;
    end
  end
endmodule // rvl_tick_div

// ---- tb/rvl_qual_props.sv ----
// Port checker for the ring qualifier.
// Assumes every register write arrives over the Avalon port.
`timescale 1ns/1ns
module rvl_qual_props #(
  parameter TICK_CYCLES = 10
) (
  input wire i_ref_clk,
  input wire i_sys_rst,
  input wire [7:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [31:0] o_avs_readdata,
  input wire o_avs_waitrequest,
  input wire i_ring_event,
  input wire o_ring_valid,
  input wire o_irq
);
  reg [7:0] c2;
  reg [7:0] c3;
  reg [31:0] since;
  wire wdone = i_avs_write && !o_avs_waitrequest;
  wire [31:0] to_cyc = c2[6:3] * 64 * TICK_CYCLES;
  // Free-running tick: allow two ticks of slack
  wire [31:0] slack = 2 * TICK_CYCLES;
  // Shadows load on the completing edge, as the design's registers do
  always @(posedge i_ref_clk or posedge i_sys_rst)
    if (i_sys_rst)
    begin
      c2 <= 8'h2D;
      c3 <= 8'h19;
      since <= 32'h0;
    end
    else
    begin
      since <= i_ring_event ? 32'h0 : since + 32'h1;
      if (wdone && i_avs_address == 8'h5C)
        c2 <= i_avs_writedata[7:0];
      if (wdone && i_avs_address == 8'h60)
        c3 <= i_avs_writedata[7:0];
    end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_rd_done;
    i_avs_read && !o_avs_waitrequest;
  endsequence
  a_wait_answer: assert property (
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("no answer after request");
  a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  a_rsvd_zero: assert property (
    s_rd_done ##0 i_avs_address == 8'h60 |-> !o_avs_readdata[6])
    else $error("reserved bit reads one");
  a_unmapped_zero: assert property (
    s_rd_done ##0 i_avs_address[7:2] > 6'h22 |-> o_avs_readdata == 0)
    else $error("unmapped read not zero");
  a_reset_clear: assert property (
    $fell(i_sys_rst) |-> !o_ring_valid && !o_irq && o_avs_waitrequest)
    else $error("outputs not cleared by reset");
  a_bypass_valid: assert property (
    !c3[7] && i_ring_event |=> o_ring_valid)
    else $error("bypass did not indicate ring");
  a_end_early: assert property (
    $fell(o_ring_valid) && !c3[7] |-> since + slack >= to_cyc)
    else $error("ring ended before timeout");
  a_end_late: assert property (
    o_ring_valid |-> since <= to_cyc + slack)
    else $error("ring outlived timeout");
endmodule // rvl_qual_props
bind rvl_ring_qual rvl_qual_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_ring_event(i_ring_event), .o_ring_valid(o_ring_valid), .o_irq(o_irq)
);

// ---- tb/rvl_ring_src.sv ----
// Line-side crossing source: a train of one-cycle crossing pulses.
// Assumes the bench sets spacing and count, then pulses go.
`timescale 1ns/1ns
module rvl_ring_src (
  input wire i_ref_clk,
  input wire [15:0] i_gap,
  input wire [7:0] i_num,
  input wire i_go,
  output reg o_ring_event = 1'b0,
  output reg o_busy = 1'b0
);
  reg [15:0] cnt = 16'h0;
  reg [7:0] left = 8'h0;
  // First pulse also waits a gap, so trains can follow back to back
  always @(posedge i_ref_clk)
  begin
    o_ring_event <= 1'b0;
    if (i_go && !o_busy)
    begin
      o_busy <= 1'b1;
      left <= i_num;
      cnt <= i_gap - 16'h1;
    end
    else if (o_busy && cnt != 16'h0)
      cnt <= cnt - 16'h1;
    else if (o_busy)
    begin
      o_ring_event <= 1'b1;
      cnt <= i_gap - 16'h1;
      left <= left - 8'h1;
      o_busy <= left != 8'h1;
    end
  end
endmodule // rvl_ring_src

// ---- tb/tb.sv ----
// Bench for the ring qualifier; reads are checked off a queue.
// Assumes a 10-cycle tick so ring timing fits a short run.
`timescale 1ns/1ns
module tb;
  localparam TK = 10;
  reg clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, go = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [31:0] wd = 32'h0;
  reg [15:0] gap = 16'h1;
  reg [7:0] num = 8'h1;
  reg [31:0] r = 32'h9DF1;
  wire [31:0] rdd;
  wire wt, ev, val, irq, busy;
  integer n_errors = 0;
  integer checks = 0;
  integer i;
  reg [7:0] exp_q[$];
  reg [7:0] msk_q[$];
  always #2 clk = ~clk;
  rvl_ring_qual #(.TICK_CYCLES(TK)) i_rvl_ring_qual (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .o_avs_readdata(rdd), .o_avs_waitrequest(wt),
    .i_ring_event(ev), .o_ring_valid(val), .o_irq(irq));
  rvl_ring_src i_rvl_ring_src (.i_ref_clk(clk), .i_gap(gap),
    .i_num(num), .i_go(go), .o_ring_event(ev), .o_busy(busy));
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string nm, input [31:0] e, input [31:0] g);
    checks = checks + 1;
    if (g !== e)
    begin
      n_errors = n_errors + 1;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task stop_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task bus(input w, input [7:0] a, input [7:0] d, input [7:0] m);
    integer k;
    if (!w)
    begin
      exp_q.push_back(d);
      msk_q.push_back(m);
    end
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= {r[31:8], d};
    k = 0;
    do
    begin
      @(posedge clk);
      k = k + 1;
    end while (wt && k < 50);
    if (wt)
      chk("waitrequest", 0, wt);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task burst(input [15:0] g, input [7:0] n);
    integer k;
    @(posedge clk);
    gap <= g;
    num <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (k = 0; busy && k < 9000; k = k + 1)
      @(posedge clk);
  endtask
  // Upper bits unmasked: they must always read zero
  always @(posedge clk)
    if (rd && !wt)
      chk("readdata", {24'h0, exp_q.pop_front()},
        rdd & {24'hFFFFFF, msk_q.pop_front()});
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(0, 8'h5C, 8'h2D, 8'hFF);
    bus(0, 8'h60, 8'h19, 8'hFF);
    bus(0, 8'h90, 8'h00, 8'hFF);
    for (i = 0; i < 3; i = i + 1)
    begin
      r = lfsr(r);
      bus(1, 8'h5C, r[7:0] | 8'h08, 0);
      bus(0, 8'h5C, r[7:0] | 8'h08, 8'hFF);
    end
    bus(1, 8'h60, 8'h59, 0);
    bus(0, 8'h60, 8'h19, 8'hFF);
    bus(1, 8'h5C, 8'h08, 0);
    burst(1, 1);
    bus(0, 8'h88, 8'h80, 8'h80);
    repeat (70 * TK) @(posedge clk);
    bus(0, 8'h88, 8'h00, 8'h80);
    bus(1, 8'h80, 8'h07, 0);
    bus(1, 8'h58, 8'h54, 0);
    bus(1, 8'h60, 8'h99, 0);
    bus(1, 8'h84, 8'h07, 0);
    burst(12 * TK, 12);
    bus(0, 8'h88, 8'h02, 8'h83);
    burst(12 * TK, 6);
    bus(0, 8'h88, 8'h83, 8'h83);
    bus(0, 8'h80, 8'h01, 8'h07);
    chk("irq", 1, irq);
    repeat (80 * TK) @(posedge clk);
    bus(0, 8'h80, 8'h03, 8'h07);
    bus(1, 8'h80, 8'h03, 0);
    repeat (2) @(posedge clk);
    chk("irq", 0, irq);
    burst(2 * TK, 2);
    bus(0, 8'h80, 8'h04, 8'h07);
    chk("irq", 1, irq);
    bus(1, 8'h84, 8'h00, 0);
    repeat (2) @(posedge clk);
    chk("irq", 0, irq);
    bus(1, 8'h80, 8'h07, 0);
    burst(30 * TK, 2);
    bus(0, 8'h88, 8'h00, 8'h83);
    bus(0, 8'h80, 8'h04, 8'h07);
    stop_test;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors = n_errors + 1;
    stop_test;
  end
endmodule // tb
